/* bench/gpm_pins_model.sv */
`default_nettype none
module gpm_pins_model import gpm_pkg::*; (
    // clock
    input wire logic clk,
    // device side of each pin
    input wire gpm_pins_t pinOut,
    input wire gpm_pins_t pinOe,
    input wire gpm_pins_t pinPullupEn,
    // outside drivers commanded by the bench
    input wire gpm_pins_t extOe,
    input wire gpm_pins_t extVal,
    // resolved pin levels
    output gpm_pins_t pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    gpm_pins_t lastLevel = '0;
    // device drive wins over the outside driver; contention is not modelled
    // a floating pin flips every cycle so a stale level never passes for a read
    always_comb begin
        for (int i = 0; i < 36; i++) begin
            pinIn[i] = pinOe[i] ? pinOut[i] : extOe[i] ? extVal[i] :
                pinPullupEn[i] ? 1'b1 : ~lastLevel[i];
        end
    end
    always_ff @(posedge clk) begin
        lastLevel <= pinIn;
    end
endmodule // gpm_pins_model
`default_nettype wire

/* bench/tb_top.sv */
`include "gpm_map.svh"
`default_nettype none
module tb_top import gpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic protectedWriteWindow = 1'b0;
    gpm_bus_req_s busReq = '0;
    logic [31:0] busRdata;
    logic busRvalid;
    gpm_pins_t pinIn, pinOut, pinOe, pinPullupEn, periphIn;
    gpm_pins_t extOe = '0, extVal = '0;
    gpm_periph_t periphOut = '0, periphOe = '0;
    logic extIrqOne, extIrqTwo, extNmi, lowPowerWake;
    int badCount = 0;
    int comparisons = 0;

    always #25 clk = ~clk;

    gpm_bank u_gpm_bank (.clk(clk), .rst_n(rst_n), .busReq(busReq),
        .protectedWriteWindow(protectedWriteWindow), .busRdata(busRdata),
        .busRvalid(busRvalid), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullupEn(pinPullupEn), .periphOut(periphOut), .periphOe(periphOe),
        .periphIn(periphIn), .extIrqOne(extIrqOne), .extIrqTwo(extIrqTwo),
        .extNmi(extNmi), .lowPowerWake(lowPowerWake));

    gpm_pins_model u_gpm_pins_model (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullupEn(pinPullupEn), .extOe(extOe), .extVal(extVal), .pinIn(pinIn));

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one access per call; a missing read answer comes back as unknown
    task automatic acc(input logic w, input logic wd, input logic p,
        input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        busReq <= '{rd: !w, wr: w, wide: wd, addr: a, wdata: d};
        protectedWriteWindow <= p;
        @(posedge clk);
        busReq <= '0;
        #1;
        q = busRvalid ? busRdata : 'x;
    endtask

    task automatic wr(input logic wd, input logic p, input logic [15:0] a,
        input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, wd, p, a, d, q);
    endtask

    task automatic rd(input logic wd, input logic [15:0] a, output logic [31:0] q);
        acc(1'b0, wd, 1'b0, a, 32'h0, q);
    endtask

    task automatic t_reset;
        logic [31:0] q;
        rd(1'b1, `GPM_A_CTRL, q);
        chk(q, 36'h0);
        rd(1'b1, `GPM_A_MUX_LO, q);
        chk(q, 36'h0);
        chk(pinPullupEn, 36'hfffffffff);
        chk(pinOe, 36'h0);
    endtask

    task automatic t_protect;
        logic [31:0] q;
        wr(1'b1, 1'b0, `GPM_A_DIR, 32'hffffffff);
        rd(1'b1, `GPM_A_DIR, q);
        chk(q, 36'h0);
        wr(1'b0, 1'b0, `GPM_IRQ1_SEL, 32'h9);
        rd(1'b0, `GPM_IRQ1_SEL, q);
        chk(q, 36'h0);
        wr(1'b0, 1'b1, `GPM_A_DIR + 16'h1, 32'h0000a5a5);
        rd(1'b1, `GPM_A_DIR, q);
        chk(q, 36'ha5a50000);
        wr(1'b1, 1'b1, `GPM_A_DIR, 32'hffffffff);
        rd(1'b1, `GPM_A_DIR, q);
        chk(q, 36'hffffffff);
        wr(1'b1, 1'b1, `GPM_B_DIR, 32'hffffffff);
        rd(1'b1, `GPM_B_DIR, q);
        chk(q, 36'hf);
        chk(pinOe, 36'hfffffffff);
        wr(1'b1, 1'b1, `GPM_A_PUD, 32'h0000ffff);
        chk(pinPullupEn, 36'hfffff0000);
    endtask

    task automatic t_data;
        logic [15:0] ad [3] = '{`GPM_A_SET, `GPM_A_CLR, `GPM_A_TGL};
        logic [31:0] m [3] = '{32'h00000f00, 32'h00000005, 32'h0000f0f0};
        logic [31:0] e [3] = '{32'h00000fa5, 32'h00000fa0, 32'h0000ff50};
        logic [31:0] q;
        wr(1'b1, 1'b0, `GPM_A_DAT, 32'ha5);
        chk(pinOut, 36'ha5);
        for (int i = 0; i < 3; i++) begin
            wr(1'b1, 1'b0, ad[i], m[i]);
            chk(pinOut, e[i]);
        end
        wr(1'b0, 1'b0, `GPM_A_DAT + 16'h1, 32'h1234);
        chk(pinOut, 36'h1234ff50);
        repeat (8) @(posedge clk);
        rd(1'b1, `GPM_A_DAT, q);
        chk(q, 36'h1234ff50);
        rd(1'b0, `GPM_A_DAT + 16'h1, q);
        chk(q, 36'h1234);
        wr(1'b1, 1'b0, `GPM_B_SET, 32'hffffffff);
        chk(pinOut[35:32], 36'hf);
    endtask

    // only the selected peripheral drives high, so a wrong index shows as 0
    task automatic t_mux;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            periphOe <= '1;
            periphOut <= gpm_periph_t'((128'h10001 << (36 * k)) >> 36);
            wr(1'b1, 1'b1, `GPM_A_MUX_LO, 32'(k));
            wr(1'b1, 1'b1, `GPM_A_MUX_HI, 32'(k));
            chk({pinOe[0], pinOut[0], pinOe[16], pinOut[16]},
                {1'b1, k != 0, 1'b1, k != 0});
        end
        wr(1'b1, 1'b1, `GPM_A_MUX_LO, 32'h0);
        wr(1'b1, 1'b1, `GPM_A_MUX_HI, 32'h0);
    endtask

    task automatic t_route;
        wr(1'b1, 1'b1, `GPM_A_DIR, 32'h0);
        wr(1'b0, 1'b1, `GPM_IRQ1_SEL, 32'h5);
        wr(1'b0, 1'b1, `GPM_IRQ2_SEL, 32'h5);
        wr(1'b0, 1'b1, `GPM_NMI_SEL, 32'h5);
        wr(1'b1, 1'b1, `GPM_WAKE_SEL, 32'h20);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            extOe <= 36'h20;
            extVal <= 36'(v) << 5;
            repeat (8) @(posedge clk);
            #1;
            chk({extIrqOne, extIrqTwo, extNmi, lowPowerWake, periphIn[5]},
                {{3{v != 0}}, v == 0, v != 0});
        end
    endtask

    // three equal samples four cycles apart: slower than the plain sync path
    task automatic t_qual;
        wr(1'b1, 1'b1, `GPM_A_CTRL, 32'h3);
        wr(1'b1, 1'b1, `GPM_A_QSEL_LO, 32'h400);
        @(posedge clk);
        extVal <= 36'h20;
        repeat (12) @(posedge clk);
        #1;
        chk(periphIn[5], 1'b0);
        repeat (5) @(posedge clk);
        #1;
        chk(periphIn[5], 1'b1);
    endtask

    task report_and_stop;
        if (badCount == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_protect;
        t_data;
        t_mux;
        t_route;
        t_qual;
        report_and_stop;
    end

    // the whole sequence needs about 130 cycles
    initial begin
        repeat (4000) @(posedge clk);
        badCount++;
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire

/* rtl/gpm_bank.sv */
`include "gpm_map.svh"
`default_nettype none
module gpm_bank import gpm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire gpm_bus_req_s busReq,
    input wire logic protectedWriteWindow,
    output logic [31:0] busRdata,
    output logic busRvalid,
    // pins
    input wire gpm_pins_t pinIn,
    output gpm_pins_t pinOut,
    output gpm_pins_t pinOe,
    output gpm_pins_t pinPullupEn,
    // peripherals
    input wire gpm_periph_t periphOut,
    input wire gpm_periph_t periphOe,
    output gpm_pins_t periphIn,
    // interrupt and wake routing
    output logic extIrqOne,
    output logic extIrqTwo,
    output logic extNmi,
    output logic lowPowerWake
);
    gpm_state_s st_reg;
    gpm_state_s st_next;
    gpm_pins_t pinSync;

    gpm_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(pinIn),
        .dout(pinSync)
    );

    // one half-word of a register, written by a 16-bit access or either half of a 32-bit one
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] base,
                                         input logic en);
        logic [15:0] r;
        r = old;
        if (en && busReq.wr && busReq.addr == base) begin
            r = busReq.wdata[15:0];
        end else if (en && busReq.wr && busReq.wide && busReq.addr == base - 16'h0001) begin
            r = busReq.wdata[31:16];
        end
        return r;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [15:0] base,
                                           input logic en);
        return {wr16(old[31:16], base + 16'h0001, en), wr16(old[15:0], base, en)};
    endfunction

    // two-bit field of pin i; port A spans two registers, port B one
    function automatic logic [1:0] field2(input logic [31:0] lo, input logic [31:0] hi,
                                          input logic [31:0] b, input int i);
        logic [1:0] f;
        if (i < 16) begin
            f = lo[2*i +: 2];
        end else if (i < 32) begin
            f = hi[2*(i-16) +: 2];
        end else begin
            f = b[2*(i-32) +: 2];
        end
        return f;
    endfunction

    // aligned 32-bit view of the register map; write-only and reserved words read zero
    function automatic logic [31:0] word32(input logic [15:0] a);
        logic [31:0] w;
        case (a)
            `GPM_A_CTRL: w = st_reg.aCtrl;
            `GPM_A_QSEL_LO: w = st_reg.aQselLo;
            `GPM_A_QSEL_HI: w = st_reg.aQselHi;
            `GPM_A_MUX_LO: w = st_reg.aMuxLo;
            `GPM_A_MUX_HI: w = st_reg.aMuxHi;
            `GPM_A_DIR: w = st_reg.aDir;
            `GPM_A_PUD: w = st_reg.aPud;
            `GPM_B_CTRL: w = st_reg.bCtrl;
            `GPM_B_QSEL_LO: w = st_reg.bQsel;
            `GPM_B_MUX_LO: w = st_reg.bMux;
            `GPM_B_DIR: w = st_reg.bDir;
            `GPM_B_PUD: w = st_reg.bPud;
            `GPM_A_DAT: w = st_reg.qual[31:0];
            `GPM_B_DAT: w = {28'h0000000, st_reg.qual[35:32]};
            `GPM_IRQ1_SEL: w = {11'h000, st_reg.irq2Sel, 11'h000, st_reg.irq1Sel};
            `GPM_NMI_SEL: w = {27'h0000000, st_reg.nmiSel};
            `GPM_WAKE_SEL: w = st_reg.wakeSel;
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction

    function automatic logic [15:0] rd16(input logic [15:0] a);
        logic [31:0] w;
        w = word32(a & 16'hfffe);
        return a[0] ? w[31:16] : w[15:0];
    endfunction

    logic prot;
    logic [35:0] lat;
    logic [35:0] dir;
    logic [1:0] fn;
    logic [1:0] qm;
    logic aSample;
    logic bSample;
    logic [15:0] sel16;

    always_comb begin
        st_next = st_reg;
        prot = protectedWriteWindow;
        lat = '0;
        dir = '0;
        fn = 2'b00;
        qm = 2'b00;
        sel16 = 16'h0000;
        // protected control registers
        st_next.aCtrl = wmerge(st_reg.aCtrl, `GPM_A_CTRL, prot);
        st_next.aQselLo = wmerge(st_reg.aQselLo, `GPM_A_QSEL_LO, prot);
        st_next.aQselHi = wmerge(st_reg.aQselHi, `GPM_A_QSEL_HI, prot);
        st_next.aMuxLo = wmerge(st_reg.aMuxLo, `GPM_A_MUX_LO, prot);
        st_next.aMuxHi = wmerge(st_reg.aMuxHi, `GPM_A_MUX_HI, prot);
        st_next.aDir = wmerge(st_reg.aDir, `GPM_A_DIR, prot);
        st_next.aPud = wmerge(st_reg.aPud, `GPM_A_PUD, prot);
        st_next.bCtrl = wmerge(st_reg.bCtrl, `GPM_B_CTRL, prot);
        st_next.bQsel = wmerge(st_reg.bQsel, `GPM_B_QSEL_LO, prot) & `GPM_B_FIELD_MASK;
        st_next.bMux = wmerge(st_reg.bMux, `GPM_B_MUX_LO, prot) & `GPM_B_FIELD_MASK;
        st_next.bDir = wmerge(st_reg.bDir, `GPM_B_DIR, prot) & `GPM_B_PIN_MASK;
        st_next.bPud = wmerge(st_reg.bPud, `GPM_B_PUD, prot) & `GPM_B_PIN_MASK;
        // interrupt and wake selects, also behind the window
        sel16 = wr16({11'h000, st_reg.irq1Sel}, `GPM_IRQ1_SEL, prot);
        st_next.irq1Sel = sel16[4:0];
        sel16 = wr16({11'h000, st_reg.irq2Sel}, `GPM_IRQ2_SEL, prot);
        st_next.irq2Sel = sel16[4:0];
        sel16 = wr16({11'h000, st_reg.nmiSel}, `GPM_NMI_SEL, prot);
        st_next.nmiSel = sel16[4:0];
        st_next.wakeSel = wmerge(st_reg.wakeSel, `GPM_WAKE_SEL, prot);

        // output latches: open to every write
        st_next.aLatch = wmerge(st_reg.aLatch, `GPM_A_DAT, 1'b1);
        st_next.aLatch = st_next.aLatch | wmerge('0, `GPM_A_SET, 1'b1);
        st_next.aLatch = st_next.aLatch & ~wmerge('0, `GPM_A_CLR, 1'b1);
        st_next.aLatch = st_next.aLatch ^ wmerge('0, `GPM_A_TGL, 1'b1);
        st_next.bLatch = wmerge(st_reg.bLatch, `GPM_B_DAT, 1'b1);
        st_next.bLatch = st_next.bLatch | wmerge('0, `GPM_B_SET, 1'b1);
        st_next.bLatch = st_next.bLatch & ~wmerge('0, `GPM_B_CLR, 1'b1);
        st_next.bLatch = st_next.bLatch ^ wmerge('0, `GPM_B_TGL, 1'b1);
        st_next.bLatch = st_next.bLatch & `GPM_B_PIN_MASK;

        // sample tick per port: period is control byte plus one cycle
        aSample = (st_reg.aTick == 8'h00);
        bSample = (st_reg.bTick == 8'h00);
        st_next.aTick = aSample ? st_reg.aCtrl[7:0] : st_reg.aTick - 8'h01;
        st_next.bTick = bSample ? st_reg.bCtrl[7:0] : st_reg.bTick - 8'h01;

        // qualification; sampled history reacts to the tick of its own port
        for (int i = 0; i < 36; i++) begin
            if ((i < 32) ? aSample : bSample) begin
                st_next.hist[i] = {st_reg.hist[i][4:0], pinSync[i]};
            end
            qm = field2(st_reg.aQselLo, st_reg.aQselHi, st_reg.bQsel, i);
            case (qm)
                GPM_Q_SHORT: begin
                    if (&st_next.hist[i][`GPM_QUAL_SHORT-1:0]
                        || ~|st_next.hist[i][`GPM_QUAL_SHORT-1:0]) begin
                        st_next.qual[i] = st_next.hist[i][0];
                    end
                end
                GPM_Q_LONG: begin
                    if (&st_next.hist[i][`GPM_QUAL_LONG-1:0]
                        || ~|st_next.hist[i][`GPM_QUAL_LONG-1:0]) begin
                        st_next.qual[i] = st_next.hist[i][0];
                    end
                end
                default: begin
                    // synchronised level; the pin sync stage is always kept for safety
                    st_next.qual[i] = pinSync[i];
                end
            endcase
        end

        // pin multiplexer, fed from the next latch state so a write shows one edge later
        lat = {st_next.bLatch[3:0], st_next.aLatch};
        dir = {st_next.bDir[3:0], st_next.aDir};
        for (int i = 0; i < 36; i++) begin
            fn = field2(st_next.aMuxLo, st_next.aMuxHi, st_next.bMux, i);
            case (fn)
                GPM_FN_IO: begin
                    st_next.pinOut[i] = lat[i];
                    st_next.pinOe[i] = dir[i];
                end
                GPM_FN_P1: begin
                    st_next.pinOut[i] = periphOut[0][i];
                    st_next.pinOe[i] = periphOe[0][i];
                end
                GPM_FN_P2: begin
                    st_next.pinOut[i] = periphOut[1][i];
                    st_next.pinOe[i] = periphOe[1][i];
                end
                default: begin
                    st_next.pinOut[i] = periphOut[2][i];
                    st_next.pinOe[i] = periphOe[2][i];
                end
            endcase
        end
        st_next.pullupEn = ~{st_next.bPud[3:0], st_next.aPud};

        // routing of qualified port A levels
        st_next.irq1 = st_next.qual[st_next.irq1Sel];
        st_next.irq2 = st_next.qual[st_next.irq2Sel];
        st_next.nmi = st_next.qual[st_next.nmiSel];
        st_next.wake = |(st_next.wakeSel & ~st_next.qual[31:0]);

        // read answer one edge after the request
        st_next.rvalid = busReq.rd;
        st_next.rdata = 32'h00000000;
        if (busReq.rd) begin
            st_next.rdata = {busReq.wide ? rd16(busReq.addr + 16'h0001) : 16'h0000,
                             rd16(busReq.addr)};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.aCtrl <= `GPM_RST_CTRL;
            st_reg.bCtrl <= `GPM_RST_CTRL;
            st_reg.aQselLo <= `GPM_RST_QSEL;
            st_reg.aQselHi <= `GPM_RST_QSEL;
            st_reg.bQsel <= `GPM_RST_QSEL;
            st_reg.aMuxLo <= `GPM_RST_MUX;
            st_reg.aMuxHi <= `GPM_RST_MUX;
            st_reg.bMux <= `GPM_RST_MUX;
            st_reg.aDir <= `GPM_RST_DIR;
            st_reg.bDir <= `GPM_RST_DIR;
            st_reg.aPud <= `GPM_RST_PUD;
            st_reg.bPud <= `GPM_RST_PUD;
            st_reg.aLatch <= `GPM_RST_LATCH;
            st_reg.bLatch <= `GPM_RST_LATCH;
            st_reg.irq1Sel <= `GPM_RST_PINSEL;
            st_reg.irq2Sel <= `GPM_RST_PINSEL;
            st_reg.nmiSel <= `GPM_RST_PINSEL;
            st_reg.wakeSel <= `GPM_RST_WAKE;
            st_reg.pullupEn <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busRdata = st_reg.rdata;
    assign busRvalid = st_reg.rvalid;
    assign pinOut = st_reg.pinOut;
    assign pinOe = st_reg.pinOe;
    assign pinPullupEn = st_reg.pullupEn;
    assign periphIn = st_reg.qual;
    assign extIrqOne = st_reg.irq1;
    assign extIrqTwo = st_reg.irq2;
    assign extNmi = st_reg.nmi;
    assign lowPowerWake = st_reg.wake;

    a_prot_dir_block: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busReq.wr && !protectedWriteWindow && busReq.addr == `GPM_A_DIR)
        |=> $stable(st_reg.aDir))
        else $error("direction written with window closed");

    a_prot_sel_block: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busReq.wr && !protectedWriteWindow && busReq.addr == `GPM_IRQ1_SEL)
        |=> $stable(st_reg.irq1Sel))
        else $error("interrupt select written with window closed");

    a_data_write_open: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busReq.wr && busReq.wide && !protectedWriteWindow && busReq.addr == `GPM_A_DAT)
        |=> st_reg.aLatch == $past(busReq.wdata))
        else $error("data latch missed an unprotected write");

    a_set_bits_or: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busReq.wr && busReq.wide && busReq.addr == `GPM_A_SET)
        |=> st_reg.aLatch == ($past(st_reg.aLatch) | $past(busReq.wdata)))
        else $error("set register did not or into latch");

    a_toggle_bits_xor: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busReq.wr && busReq.wide && busReq.addr == `GPM_A_TGL)
        |=> st_reg.aLatch == ($past(st_reg.aLatch) ^ $past(busReq.wdata)))
        else $error("toggle register did not invert latch");

    a_read_pin_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busReq.rd && busReq.wide && busReq.addr == `GPM_A_DAT)
        |=> busRvalid && busRdata == $past(st_reg.qual[31:0]))
        else $error("data read did not return pin level");

    a_half_write_hi: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busReq.wr && !busReq.wide && protectedWriteWindow
            && busReq.addr == `GPM_A_DIR + 16'h0001)
        |=> st_reg.aDir[31:16] == $past(busReq.wdata[15:0]) && $stable(st_reg.aDir[15:0]))
        else $error("16-bit write hit the wrong half");

    a_mux_io_path: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_reg.aMuxLo[1:0] == 2'b00)
        |-> pinOe[0] == st_reg.aDir[0] && pinOut[0] == st_reg.aLatch[0])
        else $error("pin 0 not on io path with zero select");

    a_mux_periph_path: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_reg.aMuxHi[1:0] == 2'b11) |-> pinOut[16] == $past(periphOut[2][16]))
        else $error("pin 16 not routed to third peripheral");

    a_portb_width: assert property (
        @(posedge clk) disable iff (!rst_n)
        st_reg.bDir[31:4] == 28'h0000000 && st_reg.bLatch[31:4] == 28'h0000000)
        else $error("port B holds bits beyond pin 35");

    a_irq_route: assert property (
        @(posedge clk) disable iff (!rst_n)
        extIrqOne == st_reg.qual[st_reg.irq1Sel] && extNmi == st_reg.qual[st_reg.nmiSel])
        else $error("interrupt source not the selected pin");

    c_prot_write: cover property (
        @(posedge clk) disable iff (!rst_n)
        busReq.wr && protectedWriteWindow && busReq.addr == `GPM_A_MUX_LO);
    c_clear_write: cover property (
        @(posedge clk) disable iff (!rst_n)
        busReq.wr && busReq.addr == `GPM_A_CLR);
    c_wake_fired: cover property (
        @(posedge clk) disable iff (!rst_n)
        $rose(lowPowerWake));
endmodule // gpm_bank
`default_nettype wire

/* rtl/gpm_map.svh */
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH

// 16-bit word addresses on the peripheral bus
`define GPM_A_CTRL 16'h6f80
`define GPM_A_QSEL_LO 16'h6f82
`define GPM_A_QSEL_HI 16'h6f84
`define GPM_A_MUX_LO 16'h6f86
`define GPM_A_MUX_HI 16'h6f88
`define GPM_A_DIR 16'h6f8a
`define GPM_A_PUD 16'h6f8c
`define GPM_B_CTRL 16'h6f90
`define GPM_B_QSEL_LO 16'h6f92
`define GPM_B_QSEL_HI 16'h6f94
`define GPM_B_MUX_LO 16'h6f96
`define GPM_B_MUX_HI 16'h6f98
`define GPM_B_DIR 16'h6f9a
`define GPM_B_PUD 16'h6f9c
`define GPM_A_DAT 16'h6fc0
`define GPM_A_SET 16'h6fc2
`define GPM_A_CLR 16'h6fc4
`define GPM_A_TGL 16'h6fc6
`define GPM_B_DAT 16'h6fc8
`define GPM_B_SET 16'h6fca
`define GPM_B_CLR 16'h6fcc
`define GPM_B_TGL 16'h6fce
`define GPM_IRQ1_SEL 16'h6fe0
`define GPM_IRQ2_SEL 16'h6fe1
`define GPM_NMI_SEL 16'h6fe2
`define GPM_WAKE_SEL 16'h6fe8

// port B implements pins 32 to 35 only
`define GPM_B_PIN_MASK 32'h0000000f
`define GPM_B_FIELD_MASK 32'h000000ff

// reset values
`define GPM_RST_CTRL 32'h00000000
`define GPM_RST_QSEL 32'h00000000
`define GPM_RST_MUX 32'h00000000
`define GPM_RST_DIR 32'h00000000
`define GPM_RST_PUD 32'h00000000
`define GPM_RST_LATCH 32'h00000000
`define GPM_RST_PINSEL 5'h00
`define GPM_RST_WAKE 32'h00000000

// qualification sample counts
`define GPM_QUAL_SHORT 3
`define GPM_QUAL_LONG 6

`endif

/* rtl/gpm_pkg.sv */
`default_nettype none
package gpm_pkg;
    typedef logic [35:0] gpm_pins_t;
    typedef logic [2:0][35:0] gpm_periph_t;

    typedef enum logic [1:0] {
        GPM_FN_IO = 2'b00,
        GPM_FN_P1 = 2'b01,
        GPM_FN_P2 = 2'b10,
        GPM_FN_P3 = 2'b11
    } gpm_fn_e;

    typedef enum logic [1:0] {
        GPM_Q_SYNC = 2'b00,
        GPM_Q_SHORT = 2'b01,
        GPM_Q_LONG = 2'b10,
        GPM_Q_ASYNC = 2'b11
    } gpm_qual_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic wide;
        logic [15:0] addr;
        logic [31:0] wdata;
    } gpm_bus_req_s;

    typedef struct packed {
        logic [31:0] aCtrl;
        logic [31:0] aQselLo;
        logic [31:0] aQselHi;
        logic [31:0] aMuxLo;
        logic [31:0] aMuxHi;
        logic [31:0] aDir;
        logic [31:0] aPud;
        logic [31:0] aLatch;
        logic [31:0] bCtrl;
        logic [31:0] bQsel;
        logic [31:0] bMux;
        logic [31:0] bDir;
        logic [31:0] bPud;
        logic [31:0] bLatch;
        logic [4:0] irq1Sel;
        logic [4:0] irq2Sel;
        logic [4:0] nmiSel;
        logic [31:0] wakeSel;
        logic [7:0] aTick;
        logic [7:0] bTick;
        logic [35:0][5:0] hist;
        logic [35:0] qual;
        logic [31:0] rdata;
        logic rvalid;
        logic [35:0] pinOut;
        logic [35:0] pinOe;
        logic [35:0] pullupEn;
        logic irq1;
        logic irq2;
        logic nmi;
        logic wake;
    } gpm_state_s;

    typedef struct packed {
        logic [35:0] s1;
        logic [35:0] s2;
        logic [35:0] s3;
        logic [35:0] level;
    } gpm_sync_s;
endpackage
`default_nettype wire

/* rtl/gpm_sync.sv */
`default_nettype none
module gpm_sync import gpm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire gpm_pins_t din,
    output gpm_pins_t dout
);
    gpm_sync_s st_reg;
    gpm_sync_s st_next;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < 36; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.level[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.level;
endmodule // gpm_sync
`default_nettype wire
